// file: rtl/thermal_cutoff.sv
// module: heater drive with thermal cutoff and loopback signal-loss mirror
`timescale 1ns/1ps
module thermal_cutoff #(
    parameter int TEMP_W = 8 // temperature reading width
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // management register access
    input thermal_cutoff_pkg::mgmt_req_s mgmt_req,
    output thermal_cutoff_pkg::mgmt_rsp_s mgmt_rsp,
    // temperature sensor
    input wire logic [TEMP_W-1:0] temp_deg,
    input wire logic temp_valid,
    // module pins
    input wire logic low_power_in,
    input wire logic transmit_disable_in,
    output logic receive_signal_loss_out,
    // heater and status
    output logic heater_pwm,
    output logic cutoff_active
);
    import thermal_cutoff_pkg::*;

    // ==========================================================================
    // registers
    logic [7:0] heater_drive_r; // duty setting, never above the duty maximum
    logic [7:0] shutdown_limit_r; // programmed limit, any byte
    logic [6:0] pwm_cnt_r; // pwm frame counter, wraps once per frame
    logic over_r; // last reading at or above the effective limit
    heat_state_e state_r; // heater state register
    heat_state_e state_nxt; // next heater state
    mgmt_rsp_s rsp_r; // registered read answer

    // ==========================================================================
    // helper functions
    // clamp a write to the heater range; a wild write cannot overdrive the heater
    function automatic logic [7:0] clamp_drive(input logic [7:0] v);
        clamp_drive = (v > HEATER_DRIVE_MAX) ? HEATER_DRIVE_MAX : v;
    endfunction : clamp_drive

    // full 16-bit address match, shared by the write and read decodes
    function automatic logic addr_is(input logic [15:0] a, input logic [15:0] target);
        addr_is = (a == target);
    endfunction : addr_is

    // ==========================================================================
    // decode
    // write strobes per register; the address is matched in full, so aliases never hit
    wire wr_drive = mgmt_req.wr && addr_is(mgmt_req.addr, HEATER_DRIVE_ADDR);
    wire wr_limit = mgmt_req.wr && addr_is(mgmt_req.addr, SHUTDOWN_LIMIT_ADDR);
    // read selects; qualified by the read strobe below
    wire rd_drive = addr_is(mgmt_req.addr, HEATER_DRIVE_ADDR);
    wire rd_limit = addr_is(mgmt_req.addr, SHUTDOWN_LIMIT_ADDR);
    wire rd_hit = mgmt_req.rd && (rd_drive || rd_limit); // mapped read
    // read data mux; unmapped places and idle cycles give zero
    wire [7:0] rd_data = !mgmt_req.rd ? 8'h00 :
        rd_drive ? heater_drive_r :
        rd_limit ? shutdown_limit_r : 8'h00;
    // effective limit: lower of programmed value and ceiling
    wire [7:0] eff_limit = (shutdown_limit_r < CEILING_DEG) ?
        shutdown_limit_r : CEILING_DEG;
    // unsigned, equal counts as reached; the reading is widened, never cut
    wire reached = ({{(16-TEMP_W){1'b0}}, temp_deg} >= {8'h00, eff_limit});
    // duty window: high for the first drive counts of each frame
    wire pwm_high = ({1'b0, pwm_cnt_r} < heater_drive_r);

    // ==========================================================================
    // register writes; limit takes any byte, drive is clamped
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            heater_drive_r <= HEATER_DRIVE_RESET;
            shutdown_limit_r <= SHUTDOWN_LIMIT_RESET;
        end else begin
            if (wr_drive) heater_drive_r <= clamp_drive(mgmt_req.wdata);
            if (wr_limit) shutdown_limit_r <= mgmt_req.wdata;
        end
    end

    // read answer, one cycle after the strobe; unmapped reads return zero
    // the answer is a flop so the host sees clean data for the whole cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_r <= '0; // no answer pending out of reset
        end else begin
            rsp_r.valid <= mgmt_req.rd;
            rsp_r.hit <= rd_hit;
            rsp_r.rdata <= rd_data;
        end
    end
    assign mgmt_rsp = rsp_r;

    // ==========================================================================
    // temperature compare, refreshed on each new reading
    always_ff @(posedge clk or posedge rst) begin
        if (rst) over_r <= 1'b0;
        else if (temp_valid) over_r <= reached;
    end

    // pwm frame counter, free running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) pwm_cnt_r <= '0;
        else if (pwm_cnt_r == 7'(PWM_PERIOD - 1)) pwm_cnt_r <= '0;
        else pwm_cnt_r <= pwm_cnt_r + 7'h01;
    end

    // heater state selection; cutoff needs no software, clears once cool
    // no hysteresis: a reading just below the limit restarts the heater
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            HEAT_OFF: begin
                if (over_r) begin
                    state_nxt = HEAT_CUT;
                end else if (!low_power_in && heater_drive_r != 8'h00) begin
                    state_nxt = HEAT_RUN;
                end
            end
            HEAT_RUN: begin
                if (over_r) begin
                    state_nxt = HEAT_CUT;
                end else if (low_power_in || heater_drive_r == 8'h00) begin
                    state_nxt = HEAT_OFF;
                end
            end
            HEAT_CUT: begin
                if (!over_r) begin
                    state_nxt = HEAT_OFF; // cool again, restart through off
                end
            end
            default: begin
                state_nxt = HEAT_OFF; // illegal code, park safely
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) state_r <= HEAT_OFF;
        else state_r <= state_nxt;
    end

    // gate also uses live conditions so the drive stops the same cycle
    // a cut never waits for the state register to catch up
    wire heat_go = (state_nxt == HEAT_RUN) && !over_r && !low_power_in;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) heater_pwm <= 1'b0;
        else heater_pwm <= heat_go && pwm_high;
    end

    // status straight from the state register
    assign cutoff_active = (state_r == HEAT_CUT);
    // passive loopback: no real detection, just mirror the pin
    assign receive_signal_loss_out = transmit_disable_in;

    // ==========================================================================
    // checks
    // reset values, looked at on the first edge after release
    limit_reset_a: assert property (@(posedge clk)
        $rose(!rst) |-> shutdown_limit_r == SHUTDOWN_LIMIT_RESET)
        else $error("limit reset value wrong");
    drive_reset_a: assert property (@(posedge clk)
        $fell(rst) |-> heater_drive_r == HEATER_DRIVE_RESET)
        else $error("drive reset value wrong");

    // register writes: drive stays in range and is clamped, in-range drive writes and all limit writes are taken as written
    drive_range_a: assert property (@(posedge clk) disable iff (rst)
        heater_drive_r <= HEATER_DRIVE_MAX)
        else $error("drive out of range");
    drive_clamp_a: assert property (@(posedge clk) disable iff (rst)
        wr_drive && mgmt_req.wdata > HEATER_DRIVE_MAX |=> heater_drive_r == HEATER_DRIVE_MAX)
        else $error("drive write not clamped");
    drive_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_drive && mgmt_req.wdata <= HEATER_DRIVE_MAX
            |=> heater_drive_r == $past(mgmt_req.wdata))
        else $error("drive write lost");
    limit_write_a: assert property (@(posedge clk) disable iff (rst)
        wr_limit |=> shutdown_limit_r == $past(mgmt_req.wdata))
        else $error("limit write lost");
    // a limit-register read answers one cycle later with the value held before any same-cycle write
    read_answer_a: assert property (@(posedge clk) disable iff (rst)
        mgmt_req.rd && rd_limit |=> mgmt_rsp.valid && mgmt_rsp.hit
            && mgmt_rsp.rdata == $past(shutdown_limit_r))
        else $error("limit read answer wrong");

    // compare against the lower of the programmed limit and the ceiling
    ceiling_use_a: assert property (@(posedge clk) disable iff (rst)
        temp_valid && temp_deg >= CEILING_DEG |=> over_r)
        else $error("ceiling not applied");
    below_use_a: assert property (@(posedge clk) disable iff (rst)
        temp_valid && shutdown_limit_r < CEILING_DEG
            && temp_deg >= shutdown_limit_r |=> over_r)
        else $error("programmed limit ignored");
    cool_clear_a: assert property (@(posedge clk) disable iff (rst)
        temp_valid && temp_deg < CEILING_DEG && temp_deg < shutdown_limit_r |=> !over_r)
        else $error("stale compare");
    equal_reach_a: assert property (@(posedge clk) disable iff (rst)
        temp_valid && {8'h00, temp_deg} == {8'h00, eff_limit} |=> over_r)
        else $error("equal not reached");

    // heater drive: off while hot, in low power, at zero duty and outside the window
    cut_off_a: assert property (@(posedge clk) disable iff (rst)
        over_r |=> !heater_pwm)
        else $error("heater on while hot");
    cut_state_a: assert property (@(posedge clk) disable iff (rst)
        over_r |=> cutoff_active)
        else $error("cutoff not shown");
    low_power_a: assert property (@(posedge clk) disable iff (rst)
        low_power_in |=> !heater_pwm)
        else $error("heater on in low power");
    zero_drive_a: assert property (@(posedge clk) disable iff (rst)
        heater_drive_r == 8'h00 |=> !heater_pwm)
        else $error("heater on at zero duty");
    duty_window_a: assert property (@(posedge clk) disable iff (rst)
        heater_pwm |-> $past(pwm_high))
        else $error("heater on outside duty window");

    // loopback pin: a plain copy, no detection in between
    los_mirror_a: assert property (@(posedge clk)
        receive_signal_loss_out == transmit_disable_in)
        else $error("signal loss not mirrored");

    // main scenarios seen
    cut_seen_c: cover property (@(posedge clk) disable iff (rst)
        state_r == HEAT_RUN ##1 state_r == HEAT_CUT);
    run_seen_c: cover property (@(posedge clk) disable iff (rst)
        heater_pwm ##1 !heater_pwm);
    recover_c: cover property (@(posedge clk) disable iff (rst)
        state_r == HEAT_CUT ##1 state_r == HEAT_OFF);
    low_power_c: cover property (@(posedge clk) disable iff (rst)
        state_r == HEAT_RUN && low_power_in ##1 state_r == HEAT_OFF);
    clamp_seen_c: cover property (@(posedge clk) disable iff (rst)
        wr_drive && mgmt_req.wdata > HEATER_DRIVE_MAX);
endmodule : thermal_cutoff

// file: rtl/thermal_cutoff_pkg.sv
// package: register map, limits and shared types for the thermal cutoff block
// ==========================================================================
// Overview of operation
// - shutdown limit register at address 0x8402
// - sample temperature, compare every new reading
// - reaching limit forces heater drive off
// - limit above 85 uses 85 ceiling
// - limit below 85 used as shutdown point
// - limit accepts 0..255, resets to 0x55
// - signal-loss output mirrors transmit-disable input
// - 8-bit heater drive register sets duty
// - heater drive holds 0..102, resets zero
// - low power state disables heater drive
package thermal_cutoff_pkg;
    // ==========================================================================
    // register map
    localparam logic [15:0] HEATER_DRIVE_ADDR = 16'h8401; // heater duty register
    localparam logic [15:0] SHUTDOWN_LIMIT_ADDR = 16'h8402; // cutoff limit register
    localparam logic [7:0] HEATER_DRIVE_RESET = 8'h00;
    localparam logic [7:0] HEATER_DRIVE_MAX = 8'h66; // 102 steps of duty
    localparam logic [7:0] SHUTDOWN_LIMIT_RESET = 8'h55;
    localparam logic [7:0] CEILING_DEG = 8'h55; // fixed 85 degC ceiling
    localparam int PWM_PERIOD = 102; // pwm frame length in clocks

    // management access toward the register file
    typedef struct packed {
        logic wr; // one-cycle write strobe
        logic rd; // one-cycle read strobe
        logic [15:0] addr;
        logic [7:0] wdata;
    } mgmt_req_s;

    // read answer
    typedef struct packed {
        logic valid; // one-cycle answer
        logic hit; // address decoded
        logic [7:0] rdata;
    } mgmt_rsp_s;

    // heater state machine
    typedef enum logic [2:0] {
        HEAT_OFF = 3'b001, // low power or zero duty
        HEAT_RUN = 3'b010, // pwm active
        HEAT_CUT = 3'b100 // thermal cutoff latched while hot
    } heat_state_e;
endpackage : thermal_cutoff_pkg

// file: test/host_port_model.sv
// host port controller model: issues management strobes toward the block
`timescale 1ns/1ps
module host_port_model
    import thermal_cutoff_pkg::*;
(
    // clock
    input wire logic clk,
    // management requests toward the block
    output thermal_cutoff_pkg::mgmt_req_s mgmt_req
);
    // ==========================================================================
    // one strobe per call, launched just after an edge and held over the taking edge
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 mgmt_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        #1 mgmt_req <= '0;
    endtask : access
    // idle bus from time zero so no strobe is seen during reset
    initial mgmt_req = '0;
endmodule : host_port_model

// file: test/loopback_thermal_cutoff_control_bench.sv
// testbench for the thermal cutoff block with a host port model
`timescale 1ns/1ps
module loopback_thermal_cutoff_control_bench;
    import thermal_cutoff_pkg::*;
    // ==========================================================================
    // stimulus and observation
    logic clk = 0, rst = 1, temp_valid = 0, low_power_in = 0, transmit_disable_in = 0;
    logic [7:0] temp_deg = 8'h00;
    mgmt_req_s mgmt_req;
    mgmt_rsp_s mgmt_rsp;
    logic receive_signal_loss_out, heater_pwm, cutoff_active;
    int fail_count = 0, tests_run = 0;
    int duty = 0; // heater high count over one frame
    logic [31:0] seed = 32'h0000E01A; // xorshift start
    logic [8:0] exp_q[$]; // expected hit and read data, oldest first
    thermal_cutoff dut(.clk(clk), .rst(rst), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
        .temp_deg(temp_deg), .temp_valid(temp_valid), .low_power_in(low_power_in),
        .transmit_disable_in(transmit_disable_in),
        .receive_signal_loss_out(receive_signal_loss_out), .heater_pwm(heater_pwm),
        .cutoff_active(cutoff_active));
    host_port_model host(.clk(clk), .mgmt_req(mgmt_req));
    // 200 MHz clock
    initial forever #2.5 clk = ~clk;
    // ==========================================================================
    // helpers
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xorshift
    task automatic check(input string what, input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check
    // note the answer first so the monitor finds it when valid arrives
    task automatic rd(input logic [15:0] a, input logic [8:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask : rd
    // present a reading, then look at heater and cutoff once the state has settled
    task automatic heat(input logic [7:0] t, input logic [1:0] e);
        @(posedge clk);
        #1 temp_deg = t;
        temp_valid = 1;
        repeat (6) @(posedge clk);
        #1 check("pwm and cutoff", {7'h00, e}, {7'h00, heater_pwm, cutoff_active});
    endtask : heat
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // ==========================================================================
    // answer monitor: every valid pulse takes the oldest note
    always @(posedge clk) begin
        if (mgmt_rsp.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected answer", 9'h000, 9'h1FF);
            end else begin
                check("read", exp_q.pop_front(), {mgmt_rsp.hit, mgmt_rsp.rdata});
            end
        end
    end
    // hang guard: a run this long counts as a mismatch
    initial begin
        #100000;
        fail_count++;
        $display("wrong value run length expected done seen timeout");
        tally_and_finish();
    end
    // ==========================================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 0;
        rd(SHUTDOWN_LIMIT_ADDR, {1'b1, SHUTDOWN_LIMIT_RESET});
        rd(HEATER_DRIVE_ADDR, 9'h100);
        rd(16'h8403, 9'h000); // unmapped place reads as a miss
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            host.access(1'b1, SHUTDOWN_LIMIT_ADDR, seed[7:0]);
            rd(SHUTDOWN_LIMIT_ADDR, {1'b1, seed[7:0]});
        end
        host.access(1'b1, SHUTDOWN_LIMIT_ADDR, 8'hFF);
        rd(SHUTDOWN_LIMIT_ADDR, 9'h1FF);
        host.access(1'b1, HEATER_DRIVE_ADDR, 8'hFF);
        rd(HEATER_DRIVE_ADDR, {1'b1, HEATER_DRIVE_MAX});
        $display("test register access done");
        // limit above the ceiling: cut at 85, release below it
        heat(8'h54, 2'b10);
        heat(8'h55, 2'b01);
        heat(8'h54, 2'b10);
        // limit below the ceiling takes over, equal counts as reached
        host.access(1'b1, SHUTDOWN_LIMIT_ADDR, 8'h30);
        heat(8'h2F, 2'b10);
        heat(8'h30, 2'b01);
        heat(8'h00, 2'b10);
        $display("test thermal cutoff done");
        @(posedge clk);
        #1 low_power_in = 1;
        repeat (2) @(posedge clk);
        #1 check("pwm in low power", 9'h000, {8'h00, heater_pwm});
        low_power_in = 0;
        $display("test low power done");
        // random duty: one full frame must show exactly the written number of high clocks
        for (int i = 0; i < 2; i++) begin
            seed = xorshift(seed);
            host.access(1'b1, HEATER_DRIVE_ADDR, {2'b00, seed[5:0]});
            repeat (3) @(posedge clk);
            duty = 0;
            repeat (PWM_PERIOD) begin
                @(posedge clk);
                #1 if (heater_pwm === 1'b1) duty++;
            end
            check("pwm duty", {3'b000, seed[5:0]}, 9'(duty));
        end
        $display("test heater duty done");
        for (int i = 0; i < 6; i++) begin
            seed = xorshift(seed);
            @(posedge clk);
            #1 transmit_disable_in = seed[0];
            #1 check("signal loss", {8'h00, seed[0]}, {8'h00, receive_signal_loss_out});
        end
        $display("test signal loss mirror done");
        // every noted read must have been answered by now
        repeat (2) @(posedge clk);
        #1 check("answers left", 9'h000, 9'(exp_q.size()));
        tally_and_finish();
    end
endmodule : loopback_thermal_cutoff_control_bench
